// ===== rtl/dcbf_pkg.sv
// Purpose: Constants, types and helpers for the two-way queue controller
// Assumes: Port clocks and all pins are sampled on I_REF_CLK
// Notes: Queue depth follows the data buffer size
package dcbf_pkg;
  localparam int DATA_W = 36;
  localparam int OFF_W = 10;
  localparam int DEPTH = 8;
  localparam int CNT_W = 4;
  localparam int PROG_BITS = 8;
  localparam logic [CNT_W-1:0] DEPTH_CNT = 4'h8;
  localparam logic [CNT_W-1:0] ONE_CNT = 4'h1;
  localparam logic [OFF_W-1:0] PRESET_HH = 10'h040;
  localparam logic [OFF_W-1:0] PRESET_HL = 10'h010;
  localparam logic [OFF_W-1:0] PRESET_LH = 10'h008;
  localparam logic [OFF_W-1:0] OFF_RESET = 10'h008;
  localparam logic WR_LVL_A = 1'b1;
  localparam logic WR_LVL_B = 1'b0;

  // Offset programming phases, Gray along the write order except the return from PG_BA_EMPTY to PG_NORMAL
  typedef enum logic [2:0] {
    PG_NORMAL = 3'h0,
    PG_AB_FULL = 3'h1,
    PG_AB_EMPTY = 3'h3,
    PG_BA_FULL = 3'h2,
    PG_BA_EMPTY = 3'h6
  } dcbf_prog_type;

  typedef struct packed {
    logic sel_n;
    logic dir;
    logic en;
    logic mbx;
  } dcbf_ctl_type;

  typedef struct packed {
    logic q_wr;
    logic q_rd;
    logic m_wr;
    logic m_rd;
    logic drive;
  } dcbf_op_type;

  // Port control decode; wr_lvl is the direction level that writes
  function automatic dcbf_op_type dcbf_decode(input dcbf_ctl_type c, input logic wr_lvl);
    logic act;
    logic wr;
    act = ~c.sel_n & c.en;
    wr = (c.dir == wr_lvl);
    dcbf_decode.q_wr = act & wr & ~c.mbx;
    dcbf_decode.q_rd = act & ~wr & ~c.mbx;
    dcbf_decode.m_wr = act & wr & c.mbx;
    dcbf_decode.m_rd = act & ~wr & c.mbx;
    dcbf_decode.drive = ~c.sel_n & ~wr;
  endfunction : dcbf_decode

  // Preset offset from the two flag selects
  function automatic logic [OFF_W-1:0] dcbf_preset(input logic hi, input logic lo);
    case ({hi, lo})
      2'h3: dcbf_preset = PRESET_HH;
      2'h2: dcbf_preset = PRESET_HL;
      default: dcbf_preset = PRESET_LH;
    endcase
  endfunction : dcbf_preset
endpackage : dcbf_pkg

// ===== rtl/dcbf_top.sv
// Purpose: Two-way queue pair with mailboxes and programmable almost flags
// Assumes: Port clocks slower than I_REF_CLK, pins synchronous to it
// Notes: Port clock edges become one-cycle enables
`timescale 1ns/100ps

module dcbf_fifo #(parameter int W = 36, parameter int D = 8, parameter int AW = $clog2(D)) (
  // Clock and clear
  input wire logic i_clk,
  input wire logic i_clr,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data,
  output logic [AW:0] o_count
);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  wire logic push;
  wire logic pop;

  // Handshake terms and status
  assign o_ready = (cnt_reg != (AW+1)'(D));
  assign o_valid = (cnt_reg != '0);
  assign push = i_valid & o_ready;
  assign pop = i_ready & o_valid;
  assign o_data = mem[rp_reg];
  assign o_count = cnt_reg;

  // Storage
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_reg] <= i_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge i_clk) begin
    if (i_clr) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg <= wp_reg + AW'(push);
      rp_reg <= rp_reg + AW'(pop);
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : dcbf_fifo

module dcbf_queue import dcbf_pkg::*; (
  // Clock and queue clear
  input wire logic i_clk,
  input wire logic i_clr,
  // Port edges and requests
  input wire logic i_wr_edge,
  input wire logic i_rd_edge,
  input wire logic i_wr_req,
  input wire logic i_rd_req,
  input wire logic i_hold,
  input wire logic i_fall_through_select_n,
  input wire logic [DATA_W-1:0] i_data,
  // Offsets
  input wire logic [OFF_W-1:0] i_empty_off,
  input wire logic [OFF_W-1:0] i_full_off,
  // Flags and output word
  output logic o_space,
  output logic o_out_flag,
  output logic o_ae_n,
  output logic o_af_n,
  output logic [DATA_W-1:0] o_data
);
  logic f_ready;
  logic f_valid;
  logic [DATA_W-1:0] f_data;
  logic [CNT_W-1:0] cnt;
  logic mode_set_reg, fall_through_select_reg, of_reg;
  logic sp1_reg, sp2_reg, af1_reg, af2_reg;
  logic ne1_reg, ne2_reg, ae1_reg, ae2_reg;
  logic [DATA_W-1:0] out_reg;
  wire logic push;
  wire logic take;
  wire logic drop;
  wire logic last_take;
  wire logic [CNT_W-1:0] free;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_clr);

  // Write gated by space flag and real room
  assign push = i_wr_edge & i_wr_req & sp2_reg & f_ready & ~i_hold;
  // Output register load: fall-through or requested read
  assign take = i_rd_edge & f_valid & (fall_through_select_reg ? (ne2_reg & (~of_reg | i_rd_req)) : (of_reg & i_rd_req));
  assign drop = i_rd_edge & fall_through_select_reg & of_reg & i_rd_req & ~take;
  assign last_take = take & (cnt == ONE_CNT);
  assign free = DEPTH_CNT - cnt;
  assign o_space = sp2_reg;
  assign o_out_flag = of_reg;
  assign o_ae_n = ae2_reg;
  assign o_af_n = af2_reg;
  assign o_data = out_reg;

  dcbf_fifo #(.W(DATA_W), .D(DEPTH)) u_mem (
    .i_clk(i_clk),
    .i_clr(i_clr),
    .i_valid(push),
    .o_ready(f_ready),
    .i_data(i_data),
    .o_valid(f_valid),
    .i_ready(take),
    .o_data(f_data),
    .o_count(cnt)
  );

  // Write-port flags and mode capture
  always_ff @(posedge i_clk) begin
    if (i_clr) begin
      {sp1_reg, sp2_reg, mode_set_reg, fall_through_select_reg} <= 4'h0;
      {af1_reg, af2_reg} <= 2'h3;
    end else if (i_wr_edge) begin
      sp1_reg <= f_ready & ~i_hold;
      sp2_reg <= sp1_reg;
      af1_reg <= (OFF_W'(free) > i_full_off);
      af2_reg <= af1_reg;
      mode_set_reg <= 1'b1;
      if (!mode_set_reg) begin
        fall_through_select_reg <= ~i_fall_through_select_n;
      end
    end
  end

  // Read-port flags
  always_ff @(posedge i_clk) begin
    if (i_clr) begin
      {ne1_reg, ne2_reg, ae1_reg, ae2_reg} <= 4'h0;
    end else if (i_rd_edge) begin
      ne1_reg <= f_valid & ~last_take;
      ne2_reg <= ne1_reg & ~last_take;
      ae1_reg <= (OFF_W'(cnt) > i_empty_off);
      ae2_reg <= ae1_reg;
    end
  end

  // Output flag and output word
  always_ff @(posedge i_clk) begin
    if (i_clr) begin
      of_reg <= 1'b0;
      out_reg <= '0;
    end else if (i_rd_edge) begin
      if (take) begin
        out_reg <= f_data;
      end
      if (fall_through_select_reg) begin
        of_reg <= take | (of_reg & ~drop);
      end else begin
        of_reg <= ne1_reg & ~last_take;
      end
    end
  end

  property p_fall_through_select_take;
    take && fall_through_select_reg |=> of_reg && out_reg == $past(f_data);
  endproperty
  a_fall_through_select_take: assert property (p_fall_through_select_take) else $error("fall-through load missed");

  property p_empty_hold;
    i_rd_edge && !of_reg && !fall_through_select_reg |=> $stable(out_reg);
  endproperty
  a_empty_hold: assert property (p_empty_hold) else $error("read taken while empty");

  property p_full_hold;
    !sp2_reg |=> cnt <= $past(cnt);
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("write taken while full");
endmodule : dcbf_queue

module dcbf_top import dcbf_pkg::*; (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // Queue resets and strap inputs
  input wire logic I_RESET_A_TO_B_QUEUE_N,
  input wire logic I_RESET_B_TO_A_QUEUE_N,
  input wire logic I_FLAG_SELECT_HIGH,
  input wire logic I_FLAG_SELECT_LOW,
  input wire logic I_FALL_THROUGH_SELECT,
  // Port A
  input wire logic I_PORT_A_CLOCK,
  input wire logic I_PORT_A_SELECT_N,
  input wire logic I_PORT_A_DIRECTION,
  input wire logic I_PORT_A_ENABLE,
  input wire logic I_PORT_A_MAILBOX_SELECT,
  input wire logic [DATA_W-1:0] I_PORT_A_DATA,
  output logic [DATA_W-1:0] O_PORT_A_DATA,
  output logic O_PORT_A_DATA_OE,
  output logic O_PORT_A_SPACE_FLAG,
  output logic O_PORT_A_OUTPUT_FLAG,
  output logic O_PORT_A_ALMOST_EMPTY_N,
  output logic O_PORT_A_ALMOST_FULL_N,
  // Port B
  input wire logic I_PORT_B_CLOCK,
  input wire logic I_PORT_B_SELECT_N,
  input wire logic I_PORT_B_DIRECTION,
  input wire logic I_PORT_B_ENABLE,
  input wire logic I_PORT_B_MAILBOX_SELECT,
  input wire logic [DATA_W-1:0] I_PORT_B_DATA,
  output logic [DATA_W-1:0] O_PORT_B_DATA,
  output logic O_PORT_B_DATA_OE,
  output logic O_PORT_B_SPACE_FLAG,
  output logic O_PORT_B_OUTPUT_FLAG,
  output logic O_PORT_B_ALMOST_EMPTY_N,
  output logic O_PORT_B_ALMOST_FULL_N,
  // Mailbox flags
  output logic O_MAIL_A_TO_B_FLAG_N,
  output logic O_MAIL_B_TO_A_FLAG_N
);
  dcbf_ctl_type a_ctl, b_ctl;
  dcbf_op_type a_op, b_op;
  dcbf_prog_type pg_reg, pg_next;
  logic a_clk_reg, b_clk_reg, r1_reg, r2_reg;
  logic [OFF_W-1:0] ab_empty_reg, ab_full_reg, ba_empty_reg, ba_full_reg;
  logic [DATA_W-1:0] mail_ab_reg, mail_ba_reg, a_out_reg, b_out_reg;
  logic [DATA_W-1:0] q1_data, q2_data;
  logic mfab_reg, mfba_reg, a_oe_reg, b_oe_reg;
  wire logic a_edge, b_edge, rise1, rise2, clr1, clr2, any_fs, prog_on, prog_wr, q1_wr;
  wire logic [OFF_W-1:0] preset;
  wire logic [OFF_W-1:0] a_prog_val;

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);

  // Port decode, edges and queue resets
  assign a_ctl = '{I_PORT_A_SELECT_N, I_PORT_A_DIRECTION, I_PORT_A_ENABLE, I_PORT_A_MAILBOX_SELECT};
  assign b_ctl = '{I_PORT_B_SELECT_N, I_PORT_B_DIRECTION, I_PORT_B_ENABLE, I_PORT_B_MAILBOX_SELECT};
  assign a_op = dcbf_decode(a_ctl, WR_LVL_A);
  assign b_op = dcbf_decode(b_ctl, WR_LVL_B);
  assign a_edge = I_PORT_A_CLOCK & ~a_clk_reg;
  assign b_edge = I_PORT_B_CLOCK & ~b_clk_reg;
  assign rise1 = I_RESET_A_TO_B_QUEUE_N & ~r1_reg;
  assign rise2 = I_RESET_B_TO_A_QUEUE_N & ~r2_reg;
  assign clr1 = I_RST | ~I_RESET_A_TO_B_QUEUE_N;
  assign clr2 = I_RST | ~I_RESET_B_TO_A_QUEUE_N;

  // Offset programming terms
  assign any_fs = I_FLAG_SELECT_HIGH | I_FLAG_SELECT_LOW;
  assign preset = dcbf_preset(I_FLAG_SELECT_HIGH, I_FLAG_SELECT_LOW);
  assign prog_on = (pg_reg != PG_NORMAL);
  assign prog_wr = a_edge & a_op.q_wr & O_PORT_A_SPACE_FLAG & prog_on;
  assign q1_wr = a_op.q_wr & ~prog_on;
  assign a_prog_val = OFF_W'(I_PORT_A_DATA[PROG_BITS-1:0]);

  // Programming phase sequencing
  always_comb begin
    pg_next = pg_reg;
    case (pg_reg)
      PG_NORMAL: pg_next = PG_NORMAL;
      PG_AB_FULL: pg_next = prog_wr ? PG_AB_EMPTY : PG_AB_FULL;
      PG_AB_EMPTY: pg_next = prog_wr ? PG_BA_FULL : PG_AB_EMPTY;
      PG_BA_FULL: pg_next = prog_wr ? PG_BA_EMPTY : PG_BA_FULL;
      PG_BA_EMPTY: pg_next = prog_wr ? PG_NORMAL : PG_BA_EMPTY;
      default: pg_next = PG_NORMAL;
    endcase
    if (rise1) begin
      pg_next = any_fs ? PG_NORMAL : PG_AB_FULL;
    end
  end

  // Edge history and phase state
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      {a_clk_reg, b_clk_reg, r1_reg, r2_reg} <= 4'h0;
      pg_reg <= PG_NORMAL;
    end else begin
      a_clk_reg <= I_PORT_A_CLOCK;
      b_clk_reg <= I_PORT_B_CLOCK;
      r1_reg <= I_RESET_A_TO_B_QUEUE_N;
      r2_reg <= I_RESET_B_TO_A_QUEUE_N;
      pg_reg <= pg_next;
    end
  end

  // Offset registers: preset at reset release or loaded from port A
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      {ab_empty_reg, ab_full_reg, ba_empty_reg, ba_full_reg} <= {4{OFF_RESET}};
    end else begin
      if (rise1 && any_fs) begin
        ab_empty_reg <= preset;
        ab_full_reg <= preset;
      end
      if (rise2 && any_fs) begin
        ba_empty_reg <= preset;
        ba_full_reg <= preset;
      end
      if (prog_wr && pg_reg == PG_AB_FULL) ab_full_reg <= a_prog_val;
      if (prog_wr && pg_reg == PG_AB_EMPTY) ab_empty_reg <= a_prog_val;
      if (prog_wr && pg_reg == PG_BA_FULL) ba_full_reg <= a_prog_val;
      if (prog_wr && pg_reg == PG_BA_EMPTY) ba_empty_reg <= a_prog_val;
    end
  end

  // Mailboxes; a write beats a far-side read in the same cycle
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      mail_ab_reg <= '0;
      mail_ba_reg <= '0;
    end else begin
      if (a_edge && a_op.m_wr) mail_ab_reg <= I_PORT_A_DATA;
      if (b_edge && b_op.m_wr) mail_ba_reg <= I_PORT_B_DATA;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (clr1) mfab_reg <= 1'b1;
    else if (a_edge && a_op.m_wr) mfab_reg <= 1'b0;
    else if (b_edge && b_op.m_rd) mfab_reg <= 1'b1;
    if (clr2) mfba_reg <= 1'b1;
    else if (b_edge && b_op.m_wr) mfba_reg <= 1'b0;
    else if (a_edge && a_op.m_rd) mfba_reg <= 1'b1;
  end

  // Registered data outputs and drive enables
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      {a_oe_reg, b_oe_reg} <= 2'h0;
      a_out_reg <= '0;
      b_out_reg <= '0;
    end else begin
      a_oe_reg <= a_op.drive;
      b_oe_reg <= b_op.drive;
      a_out_reg <= I_PORT_A_MAILBOX_SELECT ? mail_ba_reg : q2_data;
      b_out_reg <= I_PORT_B_MAILBOX_SELECT ? mail_ab_reg : q1_data;
    end
  end

  // Two independent queues, one per direction
  dcbf_queue u_a_to_b (
    .i_clk(I_REF_CLK),
    .i_clr(clr1),
    .i_wr_edge(a_edge),
    .i_rd_edge(b_edge),
    .i_wr_req(q1_wr),
    .i_rd_req(b_op.q_rd),
    .i_hold(1'b0),
    .i_fall_through_select_n(I_FALL_THROUGH_SELECT),
    .i_data(I_PORT_A_DATA),
    .i_empty_off(ab_empty_reg),
    .i_full_off(ab_full_reg),
    .o_space(O_PORT_A_SPACE_FLAG),
    .o_out_flag(O_PORT_B_OUTPUT_FLAG),
    .o_ae_n(O_PORT_B_ALMOST_EMPTY_N),
    .o_af_n(O_PORT_A_ALMOST_FULL_N),
    .o_data(q1_data)
  );

  dcbf_queue u_b_to_a (
    .i_clk(I_REF_CLK),
    .i_clr(clr2),
    .i_wr_edge(b_edge),
    .i_rd_edge(a_edge),
    .i_wr_req(b_op.q_wr),
    .i_rd_req(a_op.q_rd),
    .i_hold(prog_on),
    .i_fall_through_select_n(I_FALL_THROUGH_SELECT),
    .i_data(I_PORT_B_DATA),
    .i_empty_off(ba_empty_reg),
    .i_full_off(ba_full_reg),
    .o_space(O_PORT_B_SPACE_FLAG),
    .o_out_flag(O_PORT_A_OUTPUT_FLAG),
    .o_ae_n(O_PORT_A_ALMOST_EMPTY_N),
    .o_af_n(O_PORT_B_ALMOST_FULL_N),
    .o_data(q2_data)
  );

  assign O_PORT_A_DATA = a_out_reg;
  assign O_PORT_B_DATA = b_out_reg;
  assign O_PORT_A_DATA_OE = a_oe_reg;
  assign O_PORT_B_DATA_OE = b_oe_reg;
  assign O_MAIL_A_TO_B_FLAG_N = mfab_reg;
  assign O_MAIL_B_TO_A_FLAG_N = mfba_reg;

  property p_oe_a;
    1'b1 |=> O_PORT_A_DATA_OE == !($past(I_PORT_A_SELECT_N) || $past(I_PORT_A_DIRECTION));
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("port A drive wrong");

  property p_oe_b;
    1'b1 |=> O_PORT_B_DATA_OE == (!$past(I_PORT_B_SELECT_N) && $past(I_PORT_B_DIRECTION));
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("port B drive wrong");

  property p_mail_set;
    a_edge && a_op.m_wr && !clr1 |=> !O_MAIL_A_TO_B_FLAG_N && mail_ab_reg == $past(I_PORT_A_DATA);
  endproperty
  a_mail_set: assert property (p_mail_set) else $error("mail write not flagged");

  property p_mail_read;
    a_edge && a_op.m_rd && !(b_edge && b_op.m_wr) && !clr2 |=> O_MAIL_B_TO_A_FLAG_N;
  endproperty
  a_mail_read: assert property (p_mail_read) else $error("mail read flag not raised");

  property p_preset;
    rise1 && I_FLAG_SELECT_HIGH && !I_FLAG_SELECT_LOW |=> ab_empty_reg == PRESET_HL && ab_full_reg == PRESET_HL;
  endproperty
  a_preset: assert property (p_preset) else $error("preset not loaded");

  sequence s_prog_first;
    pg_reg == PG_AB_FULL && prog_wr && !rise1;
  endsequence
  property p_prog_first;
    s_prog_first |=> ab_full_reg == $past(a_prog_val) && pg_reg == PG_AB_EMPTY;
  endproperty
  a_prog_first: assert property (p_prog_first) else $error("first offset write wrong");

  sequence s_prog_last;
    pg_reg == PG_BA_EMPTY && prog_wr && !rise1;
  endsequence
  property p_prog_last;
    s_prog_last |=> pg_reg == PG_NORMAL && ba_empty_reg == $past(a_prog_val);
  endproperty
  a_prog_last: assert property (p_prog_last) else $error("programming did not finish");

  property p_queue_reset;
    clr1 |=> !O_PORT_B_ALMOST_EMPTY_N && O_PORT_A_ALMOST_FULL_N && O_MAIL_A_TO_B_FLAG_N && !O_PORT_A_SPACE_FLAG;
  endproperty
  a_queue_reset: assert property (p_queue_reset) else $error("queue reset flags wrong");
endmodule : dcbf_top

// ===== sim/dcbf_port_host.sv
// Purpose: Far-side bus master for one port of the queue controller
// Assumes: Port clock runs free, made from the reference clock
// Notes: Controls change only at the port clock falling edge
`timescale 1ns/100ps

module dcbf_port_host import dcbf_pkg::*; #(parameter int HALF = 3) (
  // Reference clock
  input wire logic i_ref_clk,
  // Port pins
  output logic o_clk,
  output logic o_sel_n,
  output logic o_dir,
  output logic o_en,
  output logic o_mbx,
  output logic [DATA_W-1:0] o_data
);
  int cnt = 0;
  logic clk_q = 1'b0;

  // Port clock comes from one flop only
  assign o_clk = clk_q;

  // Free running port clock, toggled off the sampling edge
  always @(negedge i_ref_clk) begin
    if (cnt == HALF - 1) begin
      clk_q <= ~clk_q;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // Pins idle at time zero
  initial begin
    o_sel_n = 1'b1;
    o_dir = 1'b0;
    o_en = 1'b0;
    o_mbx = 1'b0;
    o_data = '0;
  end

  // One port cycle; controls stay put until the next call
  task automatic cycle(input logic s, input logic d, input logic e, input logic m, input logic [DATA_W-1:0] w);
    @(negedge o_clk);
    o_sel_n = s;
    o_dir = d;
    o_en = e;
    o_mbx = m;
    o_data = e ? w : ~o_data; // Unused lines never keep the last word
    @(posedge o_clk);
  endtask : cycle
endmodule : dcbf_port_host

// ===== sim/dcbf_top_bench.sv
// Purpose: Self-checking bench for the two-way queue controller
// Assumes: Fall-through mode with port A offsets first, then presets
// Notes: A mid-run queue reset switches to presets and standard mode
`timescale 1ns/100ps

module dcbf_top_bench import dcbf_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rab_n = 1'b0;
  logic rba_n = 1'b0;
  logic fs_hi = 1'b0;
  logic fs_lo = 1'b0;
  logic fts = 1'b0;
  logic a_clk, a_sel_n, a_dir, a_en, a_mbx, a_oe, a_space, a_outf, a_ae_n, a_af_n;
  logic b_clk, b_sel_n, b_dir, b_en, b_mbx, b_oe, b_space, b_outf, b_ae_n, b_af_n;
  logic [DATA_W-1:0] a_drv, a_out, a_wire, b_drv, b_out, b_wire;
  logic mab_n, mba_n;
  int failures = 0;
  int n_checks = 0;

  // Clock and data wires resolved from both drivers
  always #10 clk = ~clk;
  assign a_wire = a_oe ? a_out : a_drv;
  assign b_wire = b_oe ? b_out : b_drv;

  dcbf_port_host #(.HALF(3)) i_dcbf_port_host_a (.i_ref_clk(clk), .o_clk(a_clk), .o_sel_n(a_sel_n),
    .o_dir(a_dir), .o_en(a_en), .o_mbx(a_mbx), .o_data(a_drv));
  dcbf_port_host #(.HALF(3)) i_dcbf_port_host_b (.i_ref_clk(clk), .o_clk(b_clk), .o_sel_n(b_sel_n),
    .o_dir(b_dir), .o_en(b_en), .o_mbx(b_mbx), .o_data(b_drv));

  dcbf_top i_dcbf_top (.I_REF_CLK(clk), .I_RST(rst), .I_RESET_A_TO_B_QUEUE_N(rab_n),
    .I_RESET_B_TO_A_QUEUE_N(rba_n), .I_FLAG_SELECT_HIGH(fs_hi), .I_FLAG_SELECT_LOW(fs_lo),
    .I_FALL_THROUGH_SELECT(fts), .I_PORT_A_CLOCK(a_clk), .I_PORT_A_SELECT_N(a_sel_n),
    .I_PORT_A_DIRECTION(a_dir), .I_PORT_A_ENABLE(a_en), .I_PORT_A_MAILBOX_SELECT(a_mbx),
    .I_PORT_A_DATA(a_wire), .O_PORT_A_DATA(a_out), .O_PORT_A_DATA_OE(a_oe), .O_PORT_A_SPACE_FLAG(a_space),
    .O_PORT_A_OUTPUT_FLAG(a_outf), .O_PORT_A_ALMOST_EMPTY_N(a_ae_n), .O_PORT_A_ALMOST_FULL_N(a_af_n),
    .I_PORT_B_CLOCK(b_clk), .I_PORT_B_SELECT_N(b_sel_n), .I_PORT_B_DIRECTION(b_dir),
    .I_PORT_B_ENABLE(b_en), .I_PORT_B_MAILBOX_SELECT(b_mbx), .I_PORT_B_DATA(b_wire),
    .O_PORT_B_DATA(b_out), .O_PORT_B_DATA_OE(b_oe), .O_PORT_B_SPACE_FLAG(b_space),
    .O_PORT_B_OUTPUT_FLAG(b_outf), .O_PORT_B_ALMOST_EMPTY_N(b_ae_n), .O_PORT_B_ALMOST_FULL_N(b_af_n),
    .O_MAIL_A_TO_B_FLAG_N(mab_n), .O_MAIL_B_TO_A_FLAG_N(mba_n));

  // Comparison, counting and verdict
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  // Port cycle shorthands and plain waits
  task automatic pa(input logic s, input logic d, input logic e, input logic m, input logic [DATA_W-1:0] w);
    i_dcbf_port_host_a.cycle(s, d, e, m, w);
  endtask : pa

  task automatic pb(input logic s, input logic d, input logic e, input logic m, input logic [DATA_W-1:0] w);
    i_dcbf_port_host_b.cycle(s, d, e, m, w);
  endtask : pb

  task automatic wait_ref(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_ref

  // Offsets from port A: ab full 2, ab empty 1, ba full 3, ba empty 2
  task automatic t_program();
    wait_ref(30);
    rab_n = 1'b1;
    rba_n = 1'b1;
    wait_ref(40);
    check(a_space, 1, "a space after queue reset");
    pa(0, 1, 1, 0, 36'hABCDEF102);
    pa(0, 1, 1, 0, 36'h000000001);
    pa(0, 1, 1, 0, 36'h000000003);
    pa(0, 1, 0, 0, 36'h0);
    wait_ref(40);
    check(b_space, 0, "b space before last offset");
    pa(0, 1, 1, 0, 36'h000000002);
    pa(0, 0, 0, 0, 36'h0);
    wait_ref(40);
    check(b_space, 1, "b space after last offset");
    check(b_outf, 0, "offset writes stored no word");
    $display("test program done");
  endtask : t_program

  // Both directions at once, then reads from both ports
  task automatic t_stream();
    fork
      begin
        for (int i = 0; i < 3; i++) pa(0, 1, 1, 0, 36'hA00000000 + i);
        pa(0, 0, 0, 0, 36'h0);
      end
      begin
        for (int i = 0; i < 3; i++) pb(0, 0, 1, 0, 36'hB00000000 + i);
        pb(0, 1, 0, 0, 36'h0);
      end
    join
    wait_ref(60);
    check(b_ae_n, 1, "ab two words above offset one");
    check(a_ae_n, 0, "ba two words at offset two");
    for (int i = 0; i < 3; i++) begin
      check(b_out, 36'hA00000000 + i, "word read on b");
      check(a_out, 36'hB00000000 + i, "word read on a");
      fork
        pb(0, 1, 1, 0, 36'h0);
        pa(0, 0, 1, 0, 36'h0);
      join
      fork
        pb(0, 1, 0, 0, 36'h0);
        pa(0, 0, 0, 0, 36'h0);
      join
      wait_ref(40);
    end
    check(b_outf, 0, "b output flag after last word");
    pb(0, 1, 1, 0, 36'h0);
    pb(0, 1, 0, 0, 36'h0);
    wait_ref(20);
    check(b_out, 36'hA00000002, "read on empty keeps word");
    $display("test stream done");
  endtask : t_stream

  // Fill until refused with port B stalled, then drain
  task automatic t_fill();
    for (int i = 0; i < 12; i++) pa(0, 1, 1, 0, 36'hC00000000 + i);
    pa(0, 1, 0, 0, 36'h0);
    wait_ref(40);
    check(a_space, 0, "space low when full");
    check(a_af_n, 0, "almost full at offset");
    for (int i = 0; i < 9; i++) begin
      check(b_out, 36'hC00000000 + i, "drained word");
      pb(0, 1, 1, 0, 36'h0);
      pb(0, 1, 0, 0, 36'h0);
      wait_ref(40);
    end
    check(b_outf, 0, "refused words never stored");
    check(a_space, 1, "space back after drain");
    $display("test fill done");
  endtask : t_fill

  // Mailboxes both ways, with a disabled attempt first
  task automatic t_mail();
    pa(0, 1, 0, 1, 36'h123456789);
    wait_ref(20);
    check(mab_n, 1, "no mail with enable low");
    pa(0, 1, 1, 1, 36'h123456789);
    pa(0, 1, 0, 0, 36'h0);
    wait_ref(20);
    check(mab_n, 0, "mail flag after a write");
    pb(0, 1, 1, 1, 36'h0);
    check(b_out, 36'h123456789, "mail seen on b");
    pb(0, 0, 1, 1, 36'h987654321);
    pb(0, 0, 0, 0, 36'h0);
    wait_ref(20);
    check(mab_n, 1, "mail flag after b read");
    check(mba_n, 0, "mail flag after b write");
    pa(0, 0, 1, 1, 36'h0);
    check(a_out, 36'h987654321, "mail seen on a");
    pa(0, 0, 0, 0, 36'h0);
    wait_ref(20);
    check(mba_n, 1, "mail flag after a read");
    $display("test mail done");
  endtask : t_mail

  // Output drive for every select and direction pair
  task automatic t_drive();
    logic ea;
    logic eb;
    for (int k = 0; k < 4; k++) begin
      fork
        pa(k[1], k[0], 0, 0, 36'h0);
        pb(k[1], k[0], 0, 0, 36'h0);
      join
      wait_ref(2);
      ea = ~k[1] & ~k[0];
      eb = ~k[1] & k[0];
      check(a_oe, ea, "port a drive");
      check(b_oe, eb, "port b drive");
    end
    $display("test drive done");
  endtask : t_drive

  // Preset offsets and standard mode after a mid-run queue reset
  task automatic t_preset();
    fs_hi = 1'b1;
    fts = 1'b1;
    rab_n = 1'b0;
    rba_n = 1'b0;
    wait_ref(20);
    rab_n = 1'b1;
    rba_n = 1'b1;
    wait_ref(40);
    check(b_space, 1, "b space without programming");
    pa(0, 1, 1, 0, 36'hD00000005);
    pa(0, 1, 0, 0, 36'h0);
    wait_ref(40);
    check(a_af_n, 0, "almost full at preset sixteen");
    check(b_outf, 1, "standard empty flag after write");
    check(b_out, 0, "standard word waits for a read");
    pb(0, 1, 1, 0, 36'h0);
    pb(0, 1, 0, 0, 36'h0);
    wait_ref(20);
    check(b_out, 36'hD00000005, "standard read word");
    check(b_outf, 0, "standard flag after last read");
    $display("test preset done");
  endtask : t_preset

  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_program();
    t_stream();
    t_fill();
    t_mail();
    t_drive();
    t_preset();
    close_out();
  end

  // Watchdog over the whole run
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    close_out();
  end
endmodule : dcbf_top_bench
